// >>> ssu_pkg.sv
// Package: register map, field layout, types and helpers of the shift and swap unit
package ssu_pkg;

   localparam logic [7:0] SSU_OFS_WORK      = 8'h00;
   localparam logic [7:0] SSU_OFS_FLAGS     = 8'h04;
   localparam logic [7:0] SSU_OFS_CMD       = 8'h08;
   localparam logic [7:0] SSU_OFS_STAT      = 8'h0c;

   localparam int         SSU_FLG_W         = 4;
   localparam int         SSU_FLG_NULL      = 0;
   localparam int         SSU_FLG_SHOUT     = 1;
   localparam int         SSU_FLG_NIB       = 2;
   localparam int         SSU_FLG_WRAP      = 3;

   localparam int         SSU_CMD_OP_LSB    = 0;
   localparam int         SSU_CMD_MEM_BIT   = 3;
   localparam int         SSU_CMD_ADDR_LSB  = 8;
   localparam int         SSU_STAT_BUSY_BIT = 0;

   localparam logic [7:0] SSU_WORK_RST      = 8'h00;
   localparam logic [3:0] SSU_FLAGS_RST     = 4'h0;

   typedef enum logic [2:0] {
      SSU_OP_SHR_Z = 3'h0,
      SSU_OP_ROR_F = 3'h1,
      SSU_OP_SHL_Z = 3'h2,
      SSU_OP_ROL_F = 3'h3,
      SSU_OP_SWAP  = 3'h4
   } ssu_op_t;

   typedef struct packed {
      ssu_op_t    op;
      logic       to_mem;
      logic [7:0] addr;
   } ssu_cmd_t;

   typedef struct packed {
      logic [7:0] value;
      logic       flag;
   } ssu_res_t;

   typedef struct packed {
      logic       rd_en;
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssu_mem_t;

   function automatic ssu_cmd_t ssu_decode_cmd(input logic [31:0] w);
      ssu_cmd_t c;
      c.op     = ssu_op_t'(w[SSU_CMD_OP_LSB +: 3]);
      c.to_mem = w[SSU_CMD_MEM_BIT];
      c.addr   = w[SSU_CMD_ADDR_LSB +: 8];
      return c;
   endfunction

   function automatic logic ssu_op_valid(input logic [31:0] w);
      return w[SSU_CMD_OP_LSB +: 3] <= 3'h4;
   endfunction

endpackage

// >>> ssu_shift_core.sv
// Combinational shifter, rotate-through-flag and nibble swap datapath
`timescale 1ns/1ps
`default_nettype none
module ssu_shift_core
   import ssu_pkg::*;
(
   input  wire ssu_op_t    op,
   input  wire logic [7:0] operand,
   input  wire logic       flag_in,
   output var  ssu_res_t   res
);

   always_comb begin
      res.value = operand;
      res.flag  = flag_in;
      case (op)
         SSU_OP_SHR_Z: begin // [RL1] [RL3]
            res.value = {1'b0, operand[7:1]};
            res.flag  = operand[0];
         end
         SSU_OP_ROR_F: begin // [RL2] [RL4]
            res.value = {flag_in, operand[7:1]};
            res.flag  = operand[0];
         end
         SSU_OP_SHL_Z: begin // [RL5] [RL7]
            res.value = {operand[6:0], 1'b0};
            res.flag  = operand[7];
         end
         SSU_OP_ROL_F: begin // [RL6] [RL8]
            res.value = {operand[6:0], flag_in};
            res.flag  = operand[7];
         end
         SSU_OP_SWAP: begin
            res.value = {operand[3:0], operand[7:4]}; // [RL9]
            res.flag  = flag_in; // [RL11]
         end
         default: begin
            res.value = operand;
            res.flag  = flag_in;
         end
      endcase
   end

endmodule
`default_nettype wire

// >>> ssu_top.sv
// Shift and swap unit: AHB-Lite registers, sequencer for memory operands, flags
//
// Contract
// [RL1] Right shift of working register: zero into bit 7, old bit 0 to flag.
// [RL2] Right rotate of working register: old flag into bit 7, old bit 0 to flag.
// [RL3] Right shift of memory byte: zero into bit 7, old bit 0 to flag.
// [RL4] Right rotate of memory byte: old flag into bit 7, old bit 0 to flag.
// [RL5] Left shift of working register: zero into bit 0, old bit 7 to flag.
// [RL6] Left rotate of working register: old flag into bit 0, old bit 7 to flag.
// [RL7] Left shift of memory byte: zero into bit 0, old bit 7 to flag.
// [RL8] Left rotate of memory byte: old flag into bit 0, old bit 7 to flag.
// [RL9] Nibble swap exchanges upper and lower halves of the working register.
// [RL10] Shifts and rotates change only the shift-out flag, even on zero result.
// [RL11] Nibble swap leaves all four status flags unchanged.
// [RL12] Memory operand: read byte, compute, write same address, working register untouched.
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssu_top
   import ssu_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP,
   output var  logic        MEM_RD_EN,
   output var  logic        MEM_WR_EN,
   output var  logic [7:0]  MEM_ADDR,
   output var  logic [7:0]  MEM_WDATA,
   input  wire logic [7:0]  MEM_RDATA,
   output var  logic [7:0]  WORK_REG,
   output var  logic [3:0]  FLAG_BITS,
   output var  logic        BUSY
);

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CALC, ST_WRITE} ssu_state_t;

   logic                 ap_valid_ff;
   logic                 nxt_ap_valid;
   logic                 ap_write_ff;
   logic                 nxt_ap_write;
   logic                 ap_hit_ff;
   logic                 nxt_ap_hit;
   logic [7:0]           ap_ofs_ff;
   logic [7:0]           nxt_ap_ofs;
   logic [31:0]          hrdata_ff;
   logic [31:0]          nxt_hrdata;
   logic                 hreadyout_ff;
   logic                 nxt_hreadyout;
   logic                 hresp_ff;
   logic                 nxt_hresp;
   logic [7:0]           work_ff;
   logic [7:0]           nxt_work;
   logic [SSU_FLG_W-1:0] flags_ff;
   logic [SSU_FLG_W-1:0] nxt_flags;
   ssu_state_t           state_ff;
   ssu_state_t           nxt_state;
   ssu_cmd_t             cmd_ff;
   ssu_cmd_t             nxt_cmd;
   ssu_mem_t             mem_ff;
   ssu_mem_t             nxt_mem;
   logic                 busy_ff;
   logic                 nxt_busy;

   logic                 wr_en;
   logic                 sw_work_wr;
   logic                 sw_flags_wr;
   ssu_cmd_t             new_cmd;
   logic                 cmd_go;
   logic                 reg_fire;
   logic                 mem_fire;
   ssu_op_t              core_op;
   logic [7:0]           core_operand;
   ssu_res_t             core_res;

   function automatic logic [31:0] read_mux(input logic [7:0] ofs);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (ofs)
         SSU_OFS_WORK:  d[7:0] = work_ff;
         SSU_OFS_FLAGS: d[SSU_FLG_W-1:0] = flags_ff;
         SSU_OFS_CMD:   d = {16'h0000, cmd_ff.addr, 4'h0, cmd_ff.to_mem, cmd_ff.op};
         SSU_OFS_STAT:  d[SSU_STAT_BUSY_BIT] = busy_ff;
         default:       d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic ofs_hit(input logic [31:0] a);
      return (a[31:8] == 24'h00_0000) && (a[1:0] == 2'h0) && (a[7:0] <= SSU_OFS_STAT);
   endfunction

   // Bus address phase; zero wait states, so the read word is fetched here
   always_comb begin
      nxt_ap_valid = 1'b0;
      nxt_ap_write = 1'b0;
      nxt_ap_hit   = 1'b0;
      nxt_ap_ofs   = ap_ofs_ff;
      nxt_hrdata   = hrdata_ff;
      // Zero wait states and always OKAY, still launched from a flop
      nxt_hreadyout = 1'b1;
      nxt_hresp     = 1'b0;
      if (HSEL && HREADY && HTRANS[1]) begin
         nxt_ap_valid = 1'b1;
         nxt_ap_write = HWRITE;
         nxt_ap_hit   = ofs_hit(HADDR);
         nxt_ap_ofs   = HADDR[7:0];
         if (!HWRITE) begin
            nxt_hrdata = ofs_hit(HADDR) ? read_mux(HADDR[7:0]) : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ap_valid_ff <= 1'b0;
         ap_write_ff <= 1'b0;
         ap_hit_ff   <= 1'b0;
         ap_ofs_ff   <= 8'h00;
         hrdata_ff   <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else begin
         ap_valid_ff <= nxt_ap_valid;
         ap_write_ff <= nxt_ap_write;
         ap_hit_ff   <= nxt_ap_hit;
         ap_ofs_ff   <= nxt_ap_ofs;
         hrdata_ff   <= nxt_hrdata;
         hreadyout_ff <= nxt_hreadyout;
         hresp_ff     <= nxt_hresp;
      end
   end

   assign wr_en       = ap_valid_ff && ap_write_ff && ap_hit_ff;
   assign sw_work_wr  = wr_en && (ap_ofs_ff == SSU_OFS_WORK);
   assign sw_flags_wr = wr_en && (ap_ofs_ff == SSU_OFS_FLAGS);
   assign new_cmd     = ssu_decode_cmd(HWDATA);
   // Commands while busy or with unknown codes are dropped; STAT shows busy
   assign cmd_go      = wr_en && (ap_ofs_ff == SSU_OFS_CMD) && (state_ff == ST_IDLE)
                        && ssu_op_valid(HWDATA);
   // Swap has no memory form, so its memory bit is ignored
   assign mem_fire    = cmd_go && new_cmd.to_mem && (new_cmd.op != SSU_OP_SWAP);
   assign reg_fire    = cmd_go && !mem_fire;

   assign core_op      = (state_ff == ST_CALC) ? cmd_ff.op : new_cmd.op;
   assign core_operand = (state_ff == ST_CALC) ? MEM_RDATA : work_ff; // [RL12]

   ssu_shift_core u_core (
      .op      (core_op),
      .operand (core_operand),
      .flag_in (flags_ff[SSU_FLG_SHOUT]),
      .res     (core_res)
   );

   // Datapath state and memory sequencer
   always_comb begin
      nxt_work     = work_ff;
      nxt_flags    = flags_ff;
      nxt_state    = state_ff;
      nxt_cmd      = cmd_ff;
      nxt_mem      = mem_ff;
      nxt_mem.rd_en = 1'b0;
      nxt_mem.wr_en = 1'b0;
      if (sw_work_wr) begin
         nxt_work = HWDATA[7:0];
      end
      if (sw_flags_wr) begin
         nxt_flags = HWDATA[SSU_FLG_W-1:0];
      end
      case (state_ff)
         ST_IDLE: begin
            if (mem_fire) begin // [RL12]
               nxt_cmd       = new_cmd;
               nxt_mem.rd_en = 1'b1;
               nxt_mem.addr  = new_cmd.addr;
               nxt_state     = ST_READ;
            end else if (reg_fire) begin
               nxt_work                = core_res.value; // [RL1] [RL2] [RL5] [RL6] [RL9]
               nxt_flags[SSU_FLG_SHOUT] = core_res.flag; // [RL10] [RL11]
            end
         end
         ST_READ: begin
            nxt_state = ST_CALC;
         end
         ST_CALC: begin
            // Hardware flag update is applied last so it beats a software write
            nxt_mem.wr_en            = 1'b1;
            nxt_mem.wdata            = core_res.value; // [RL3] [RL4] [RL7] [RL8]
            nxt_flags[SSU_FLG_SHOUT] = core_res.flag; // [RL10]
            nxt_state                = ST_WRITE;
         end
         ST_WRITE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_busy = (nxt_state != ST_IDLE);
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         work_ff  <= SSU_WORK_RST;
         flags_ff <= SSU_FLAGS_RST;
         state_ff <= ST_IDLE;
         cmd_ff   <= '0;
         mem_ff   <= '0;
         busy_ff  <= 1'b0;
      end else begin
         work_ff  <= nxt_work;
         flags_ff <= nxt_flags;
         state_ff <= nxt_state;
         cmd_ff   <= nxt_cmd;
         mem_ff   <= nxt_mem;
         busy_ff  <= nxt_busy;
      end
   end

   assign HRDATA    = hrdata_ff;
   assign HREADYOUT = hreadyout_ff;
   assign HRESP     = hresp_ff;
   assign MEM_RD_EN = mem_ff.rd_en;
   assign MEM_WR_EN = mem_ff.wr_en;
   assign MEM_ADDR  = mem_ff.addr;
   assign MEM_WDATA = mem_ff.wdata;
   assign WORK_REG  = work_ff;
   assign FLAG_BITS = flags_ff;
   assign BUSY      = busy_ff;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   function automatic logic [2:0] other_flags(input logic [SSU_FLG_W-1:0] f);
      return {f[SSU_FLG_WRAP], f[SSU_FLG_NIB], f[SSU_FLG_NULL]};
   endfunction

   property p_shr_z_work;
      reg_fire && (new_cmd.op == SSU_OP_SHR_Z) |=>
         (work_ff == {1'b0, $past(work_ff[7:1])}) && (flags_ff[SSU_FLG_SHOUT] == $past(work_ff[0]));
   endproperty
   a_shr_z_work: assert property (p_shr_z_work) else $error("right shift of work wrong"); // [RL1]

   property p_ror_f_work;
      reg_fire && (new_cmd.op == SSU_OP_ROR_F) |=>
         (work_ff == {$past(flags_ff[SSU_FLG_SHOUT]), $past(work_ff[7:1])})
         && (flags_ff[SSU_FLG_SHOUT] == $past(work_ff[0]));
   endproperty
   a_ror_f_work: assert property (p_ror_f_work) else $error("right rotate of work wrong"); // [RL2]

   property p_shl_z_work;
      reg_fire && (new_cmd.op == SSU_OP_SHL_Z) |=>
         (work_ff == {$past(work_ff[6:0]), 1'b0}) && (flags_ff[SSU_FLG_SHOUT] == $past(work_ff[7]));
   endproperty
   a_shl_z_work: assert property (p_shl_z_work) else $error("left shift of work wrong"); // [RL5]

   property p_rol_f_work;
      reg_fire && (new_cmd.op == SSU_OP_ROL_F) |=>
         (work_ff == {$past(work_ff[6:0]), $past(flags_ff[SSU_FLG_SHOUT])})
         && (flags_ff[SSU_FLG_SHOUT] == $past(work_ff[7]));
   endproperty
   a_rol_f_work: assert property (p_rol_f_work) else $error("left rotate of work wrong"); // [RL6]

   property p_swap_work;
      reg_fire && (new_cmd.op == SSU_OP_SWAP) |=> work_ff == {$past(work_ff[3:0]), $past(work_ff[7:4])};
   endproperty
   a_swap_work: assert property (p_swap_work) else $error("nibble swap wrong"); // [RL9]

   property p_swap_flags;
      reg_fire && (new_cmd.op == SSU_OP_SWAP) |=> $stable(flags_ff);
   endproperty
   a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags"); // [RL11]

   property p_mem_result(ssu_op_t o, logic [7:0] v, logic f);
      (state_ff == ST_CALC) && (cmd_ff.op == o) |=>
         MEM_WR_EN && (MEM_WDATA == v) && (flags_ff[SSU_FLG_SHOUT] == f);
   endproperty
   property p_mem_shr_z;
      p_mem_result(SSU_OP_SHR_Z, {1'b0, $past(MEM_RDATA[7:1])}, $past(MEM_RDATA[0]));
   endproperty
   a_mem_shr_z: assert property (p_mem_shr_z) else $error("memory right shift wrong"); // [RL3]
   property p_mem_ror_f;
      p_mem_result(SSU_OP_ROR_F, {$past(flags_ff[SSU_FLG_SHOUT]), $past(MEM_RDATA[7:1])},
                   $past(MEM_RDATA[0]));
   endproperty
   a_mem_ror_f: assert property (p_mem_ror_f) else $error("memory right rotate wrong"); // [RL4]
   property p_mem_shl_z;
      p_mem_result(SSU_OP_SHL_Z, {$past(MEM_RDATA[6:0]), 1'b0}, $past(MEM_RDATA[7]));
   endproperty
   a_mem_shl_z: assert property (p_mem_shl_z) else $error("memory left shift wrong"); // [RL7]
   property p_mem_rol_f;
      p_mem_result(SSU_OP_ROL_F, {$past(MEM_RDATA[6:0]), $past(flags_ff[SSU_FLG_SHOUT])},
                   $past(MEM_RDATA[7]));
   endproperty
   a_mem_rol_f: assert property (p_mem_rol_f) else $error("memory left rotate wrong"); // [RL8]

   property p_shift_flags;
      ((reg_fire && (new_cmd.op != SSU_OP_SWAP)) || ((state_ff == ST_CALC) && !sw_flags_wr))
         |=> other_flags(flags_ff) == other_flags($past(flags_ff));
   endproperty
   a_shift_flags: assert property (p_shift_flags) else $error("shift touched other flags"); // [RL10]

   sequence s_mem_read;
      MEM_RD_EN && !MEM_WR_EN;
   endsequence
   sequence s_mem_write;
      !MEM_RD_EN && MEM_WR_EN;
   endsequence
   property p_mem_walk;
      mem_fire |=> s_mem_read ##1 (!MEM_RD_EN && !MEM_WR_EN) ##1 s_mem_write
         ##0 (MEM_ADDR == $past(new_cmd.addr, 3)) ##1 (!MEM_WR_EN && !BUSY);
   endproperty
   a_mem_walk: assert property (p_mem_walk) else $error("memory sequence wrong"); // [RL12]

   property p_mem_keeps_work;
      (state_ff == ST_CALC) && !sw_work_wr |=> $stable(work_ff);
   endproperty
   a_mem_keeps_work: assert property (p_mem_keeps_work) else $error("work changed by memory op"); // [RL12]

endmodule
`default_nettype wire

// >>> ssu_mem_model.sv
// Data memory model on the far side of the unit's byte read and write strobes
`timescale 1ns/1ps
`default_nettype none
module ssu_mem_model (
   input  wire logic       clk,
   input  wire logic       rd_en,
   input  wire logic       wr_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] rdata
);
   logic [7:0] mem [256];

   initial rdata = 8'h5a;

   always @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      // Stale data flips every cycle so a late sample cannot pass by luck
      if (rd_en) begin
         rdata <= mem[addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule
`default_nettype wire

// >>> shift_swap_unit_tb_top.sv
// Self-checking testbench of the shift and swap unit
`timescale 1ns/1ps
`default_nettype none
`define SSU_CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module shift_swap_unit_tb_top
   import ssu_pkg::*;
;
   logic        clk;
   logic        reset_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        mem_rd_en;
   logic        mem_wr_en;
   logic [7:0]  mem_addr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic [7:0]  work_reg;
   logic [3:0]  flag_bits;
   logic        busy;
   logic [31:0] rd;
   int          n_mismatch;
   int          check_count;

   ssu_top i_ssu_top (.CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout),
      .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .MEM_RD_EN(mem_rd_en), .MEM_WR_EN(mem_wr_en), .MEM_ADDR(mem_addr),
      .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .WORK_REG(work_reg),
      .FLAG_BITS(flag_bits), .BUSY(busy));

   ssu_mem_model i_ssu_mem_model (.clk(clk), .rd_en(mem_rd_en), .wr_en(mem_wr_en),
      .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));

   always #20 clk = ~clk;

   // Returns {flag, value}; independent of the design's datapath
   function automatic logic [8:0] exp_res(input logic [2:0] op, input logic [7:0] v,
                                          input logic f);
      case (op)
         3'h0:    return {v[0], 1'b0, v[7:1]};
         3'h1:    return {v[0], f, v[7:1]};
         3'h2:    return {v[7], v[6:0], 1'b0};
         3'h3:    return {v[7], v[6:0], f};
         default: return {f, v[3:0], v[7:4]};
      endcase
   endfunction

   // Caller enters just after a rising edge; no wait-state count is assumed
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      hsize  <= 3'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic t_reset;
      logic [7:0] al [4];
      al = '{SSU_OFS_WORK, SSU_OFS_FLAGS, SSU_OFS_STAT, 8'h10};
      `SSU_CHK("work port", 8'h00, work_reg)
      `SSU_CHK("flag port", 4'h0, flag_bits)
      `SSU_CHK("read strobe", 1'b0, mem_rd_en)
      `SSU_CHK("write strobe", 1'b0, mem_wr_en)
      `SSU_CHK("busy", 1'b0, busy)
      `SSU_CHK("hreadyout", 1'b1, hreadyout)
      bus(1'b1, SSU_OFS_STAT, 32'h1);
      foreach (al[i]) begin
         bus(1'b0, al[i], 32'h0);
         `SSU_CHK("reset read", 32'h0, rd)
         `SSU_CHK("hresp", 1'b0, hresp)
      end
      $display("test reset done");
   endtask

   task automatic t_reg_ops;
      logic [7:0] vl [3];
      logic [3:0] fl [2];
      logic [8:0] e;
      logic [3:0] ef;
      vl = '{8'h81, 8'h01, 8'h80};
      fl = '{4'hd, 4'h2};
      for (int op = 0; op < 5; op++) begin
         foreach (vl[i]) begin
            foreach (fl[j]) begin
               bus(1'b1, SSU_OFS_WORK, {24'h0, vl[i]});
               bus(1'b1, SSU_OFS_FLAGS, {28'h0, fl[j]});
               bus(1'b1, SSU_OFS_CMD, {29'h0, op[2:0]});
               e  = exp_res(op[2:0], vl[i], fl[j][SSU_FLG_SHOUT]);
               ef = (op == 4) ? fl[j] : {fl[j][3:2], e[8], fl[j][0]};
               bus(1'b0, SSU_OFS_WORK, 32'h0);
               `SSU_CHK("work", {24'h0, e[7:0]}, rd)
               bus(1'b0, SSU_OFS_FLAGS, 32'h0);
               `SSU_CHK("flags", {28'h0, ef}, rd)
               `SSU_CHK("work port", e[7:0], work_reg)
            end
         end
      end
      // Unknown op code is dropped; swap ignores the memory bit and never goes busy
      bus(1'b1, SSU_OFS_WORK, 32'h81);
      bus(1'b1, SSU_OFS_FLAGS, 32'h2);
      bus(1'b1, SSU_OFS_CMD, 32'h7);
      bus(1'b1, SSU_OFS_CMD, 32'h400c);
      bus(1'b0, SSU_OFS_WORK, 32'h0);
      `SSU_CHK("swap with memory bit", 32'h18, rd)
      `SSU_CHK("busy", 1'b0, busy)
      bus(1'b0, SSU_OFS_FLAGS, 32'h0);
      `SSU_CHK("flags", 32'h2, rd)
      $display("test register operand done");
   endtask

   task automatic t_mem_ops;
      logic [7:0] a;
      logic [3:0] f;
      logic [8:0] e;
      for (int op = 0; op < 4; op++) begin
         for (int j = 0; j < 2; j++) begin
            a = 8'h40 + 8'(op);
            f = j[0] ? 4'hf : 4'h0;
            i_ssu_mem_model.mem[a] = 8'h81;
            e = exp_res(op[2:0], 8'h81, f[SSU_FLG_SHOUT]);
            bus(1'b1, SSU_OFS_WORK, 32'h5a);
            bus(1'b1, SSU_OFS_FLAGS, {28'h0, f});
            bus(1'b1, SSU_OFS_CMD, {16'h0, a, 4'h0, 1'b1, op[2:0]});
            // Swap while busy must be dropped, so the working register stays put
            bus(1'b1, SSU_OFS_CMD, {29'h0, 3'h4});
            for (int k = 0; k < 8; k++) begin
               @(negedge clk);
               if (busy !== 1'b1) break;
            end
            `SSU_CHK("busy", 1'b0, busy)
            `SSU_CHK("mem byte", e[7:0], i_ssu_mem_model.mem[a])
            `SSU_CHK("mem addr", a, mem_addr)
            `SSU_CHK("work kept", 8'h5a, work_reg)
            `SSU_CHK("flags", {f[3:2], e[8], f[0]}, flag_bits)
            @(posedge clk);
            // Dropped swap must not disturb the stored memory command
            bus(1'b0, SSU_OFS_CMD, 32'h0);
            `SSU_CHK("command readback", {16'h0, a, 4'h0, 1'b1, op[2:0]}, rd)
         end
      end
      $display("test memory operand done");
   endtask

   initial begin
      clk         = 1'b0;
      reset_n     = 1'b0;
      hsel        = 1'b0;
      haddr       = 32'h0;
      htrans      = 2'h0;
      hwrite      = 1'b0;
      hsize       = 3'h2;
      hwdata      = 32'h0;
      n_mismatch  = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_reg_ops();
      t_mem_ops();
      close_out();
   end

   // Whole run needs roughly 420 cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule
`undef SSU_CHK
`default_nettype wire
